// >>> src/mesf_event_status_regs.vh
// register indices, field positions and reset values of the event status block
`ifndef MESF_EVENT_STATUS_REGS_VH
`define MESF_EVENT_STATUS_REGS_VH
`define MESF_ADDR_W 18
`define MESF_IDX_W 16
`define MESF_STATUS_IDX 16'hE503
`define MESF_IDLE_PHASE_IDX 16'hE600
`define MESF_PHASE_EVT_IDX 16'hE601
`define MESF_IMBAL_THR_IDX 16'hE602
`define MESF_PEAK_CAP_IDX 16'hE603
`define MESF_BIT_IDLE_TOTAL 0
`define MESF_BIT_IDLE_FUND 1
`define MESF_BIT_IDLE_APPAR 2
`define MESF_BIT_MISS_VOLT 3
`define MESF_BIT_MISS_CURR 6
`define MESF_BIT_SEEN_VOLT 9
`define MESF_BIT_SEEN_CURR 12
`define MESF_BIT_RESET_DONE 15
`define MESF_BIT_DIP 16
`define MESF_BIT_HIGH_CURR 17
`define MESF_BIT_HIGH_VOLT 18
`define MESF_BIT_ORDER_FAULT 19
`define MESF_BIT_IMBALANCE 20
`define MESF_BIT_PEAK_DONE 23
`define MESF_STATUS_RESET 32'h0020_8000
`define MESF_STATUS_FIXED 32'h0020_0000
`define MESF_FLAG_MASK 32'h009F_FFFF
`define MESF_FLD_IDLE_TOTAL 0
`define MESF_FLD_IDLE_FUND 3
`define MESF_FLD_IDLE_APPAR 6
`define MESF_FLD_HIGH_CURR 3
`define MESF_FLD_HIGH_VOLT 9
`define MESF_FLD_DIP 12
`define MESF_FLD_PEAK_PHASE 24
`define MESF_MODE_NORMAL 2'h0
`define MESF_RESP_OKAY 2'h0
`define MESF_RESP_SLVERR 2'h2
`endif

// >>> src/mesf_event_status.v
// event status flags of a three-phase metering core with an axi4-lite slave
// Overview of operation
// - bit 0: total-power idle, phase in [2:0]
// - bit 1: fundamental-power idle, phase in [5:3]
// - bit 2: apparent-power idle, phase in [8:6]
// - bits 3-5: missing voltage crossing per phase
// - bits 6-8: missing current crossing per phase
// - bits 9-11: voltage crossing seen per phase
// - bits 12-14: current crossing seen per phase
// - bit 15 set after any reset; default 1
// - reset-done flag drives interrupt low, unmaskable
// - bit 16: dip entered or left, phase [14:12]
// - bit 17: overcurrent, phase in [5:3]
// - bit 18: overvoltage, phase in [11:9]
// - bit 19: rising A followed by C, not B
// - bit 20: neutral imbalance above threshold
// - bit 21 reads one, bit 22 zero
// - bit 23: peak period end, peak captured
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "mesf_event_status_regs.vh"
module mesf_event_status #(
    parameter CUR_W = 28,
    parameter PEAK_W = 24
) (
    input wire clock,
    input wire srst,
    input wire [`MESF_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`MESF_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire idle_total_power_flag_set,
    input wire [2:0] idle_total_phase_field_in,
    input wire idle_fundamental_power_flag_set,
    input wire [2:0] idle_fundamental_phase_field_in,
    input wire idle_apparent_power_flag_set,
    input wire [2:0] idle_apparent_phase_field_in,
    input wire missing_crossing_volt_a,
    input wire missing_crossing_volt_b,
    input wire missing_crossing_volt_c,
    input wire missing_crossing_curr_a,
    input wire missing_crossing_curr_b,
    input wire missing_crossing_curr_c,
    input wire crossing_seen_volt_a,
    input wire crossing_seen_volt_b,
    input wire crossing_seen_volt_c,
    input wire crossing_seen_curr_a,
    input wire crossing_seen_curr_b,
    input wire crossing_seen_curr_c,
    input wire crossing_rise_volt_a,
    input wire crossing_rise_volt_b,
    input wire crossing_rise_volt_c,
    input wire software_reset_command,
    input wire [1:0] power_mode,
    input wire dip_event,
    input wire [2:0] dip_phase_field_in,
    input wire high_current_event_flag_set,
    input wire [2:0] high_current_phase_field_in,
    input wire high_voltage_event_flag_set,
    input wire [2:0] high_voltage_phase_field_in,
    input wire neutral_check_strobe,
    input wire [CUR_W-1:0] phase_current_total,
    input wire [CUR_W-1:0] neutral_current_sample,
    input wire current_peak_period_done,
    input wire [PEAK_W-1:0] current_peak_value,
    input wire [2:0] current_peak_phase,
    output reg second_interrupt_line_n
);

    localparam SEQ_IDLE = 1'b0;
    localparam SEQ_ARMED = 1'b1;

    reg [31:0] event_status_one;
    reg [8:0] idle_phase_indicator_reg;
    reg [14:0] phase_event_status_reg;
    reg [CUR_W-1:0] neutral_imbalance_threshold;
    reg [31:0] current_peak_capture_reg;
    reg seq_state;
    reg next_seq_state;
    reg order_fault;
    reg [1:0] power_mode_prev;
    reg aw_held;
    reg w_held;
    reg [`MESF_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] set_vec;
    reg [31:0] clr_vec;
    reg [31:0] next_status;

    wire [CUR_W-1:0] mag_sum;
    wire [CUR_W-1:0] mag_neutral;
    wire [CUR_W-1:0] mag_gap;
    wire imbalance;
    wire soft_default;
    wire write_do;
    wire [`MESF_IDX_W-1:0] write_idx;
    wire [31:0] write_mask;
    wire [31:0] write_bytes;

    // signed magnitude; the most negative code maps to 2^(w-1), still exact unsigned
    function [CUR_W-1:0] mesf_abs;
        input [CUR_W-1:0] v;
        begin
            mesf_abs = v[CUR_W-1] ? (~v + 1'b1) : v;
        end
    endfunction

    function [`MESF_IDX_W-1:0] mesf_index;
        input [`MESF_ADDR_W-1:0] addr;
        begin
            mesf_index = addr[`MESF_ADDR_W-1:2];
        end
    endfunction

    function mesf_mapped;
        input [`MESF_IDX_W-1:0] idx;
        begin
            case (idx)
                `MESF_STATUS_IDX,
                `MESF_IDLE_PHASE_IDX,
                `MESF_PHASE_EVT_IDX,
                `MESF_IMBAL_THR_IDX,
                `MESF_PEAK_CAP_IDX: mesf_mapped = 1'b1;
                default: mesf_mapped = 1'b0;
            endcase
        end
    endfunction

    function [31:0] mesf_strb_mask;
        input [3:0] strb;
        begin
            mesf_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    // the magnitude difference is taken both ways so the comparison never wraps
    assign mag_sum = mesf_abs(phase_current_total);
    assign mag_neutral = mesf_abs(neutral_current_sample);
    assign mag_gap = (mag_sum > mag_neutral) ? (mag_sum - mag_neutral) : (mag_neutral - mag_sum);
    assign imbalance = neutral_check_strobe && (mag_gap > neutral_imbalance_threshold);

    // software reset or return to normal mode restores the register defaults, but not the bus, interrupt line or mode history
    assign soft_default = software_reset_command ||
        ((power_mode_prev != `MESF_MODE_NORMAL) && (power_mode == `MESF_MODE_NORMAL));

    assign write_do = aw_held && w_held && !s_axi_bvalid;
    assign write_idx = mesf_index(aw_addr);
    assign write_bytes = mesf_strb_mask(w_strb);
    assign write_mask = w_data & write_bytes;

    always @*
    begin
        next_seq_state = seq_state;
        order_fault = 1'b0;
        case (seq_state)
            SEQ_IDLE:
            begin
                if (crossing_rise_volt_a)
                    next_seq_state = SEQ_ARMED;
            end
            SEQ_ARMED:
            begin
                // b wins a tie with c since the correct order has been shown
                if (crossing_rise_volt_b)
                    next_seq_state = crossing_rise_volt_a ? SEQ_ARMED : SEQ_IDLE;
                else if (crossing_rise_volt_c)
                begin
                    order_fault = 1'b1;
                    next_seq_state = crossing_rise_volt_a ? SEQ_ARMED : SEQ_IDLE;
                end
            end
            default: next_seq_state = SEQ_IDLE;
        endcase
    end

    always @*
    begin
        set_vec = 32'h0000_0000;
        set_vec[`MESF_BIT_IDLE_TOTAL] = idle_total_power_flag_set;
        set_vec[`MESF_BIT_IDLE_FUND] = idle_fundamental_power_flag_set;
        set_vec[`MESF_BIT_IDLE_APPAR] = idle_apparent_power_flag_set;
        set_vec[`MESF_BIT_MISS_VOLT] = missing_crossing_volt_a;
        set_vec[`MESF_BIT_MISS_VOLT+1] = missing_crossing_volt_b;
        set_vec[`MESF_BIT_MISS_VOLT+2] = missing_crossing_volt_c;
        set_vec[`MESF_BIT_MISS_CURR] = missing_crossing_curr_a;
        set_vec[`MESF_BIT_MISS_CURR+1] = missing_crossing_curr_b;
        set_vec[`MESF_BIT_MISS_CURR+2] = missing_crossing_curr_c;
        set_vec[`MESF_BIT_SEEN_VOLT] = crossing_seen_volt_a;
        set_vec[`MESF_BIT_SEEN_VOLT+1] = crossing_seen_volt_b;
        set_vec[`MESF_BIT_SEEN_VOLT+2] = crossing_seen_volt_c;
        set_vec[`MESF_BIT_SEEN_CURR] = crossing_seen_curr_a;
        set_vec[`MESF_BIT_SEEN_CURR+1] = crossing_seen_curr_b;
        set_vec[`MESF_BIT_SEEN_CURR+2] = crossing_seen_curr_c;
        set_vec[`MESF_BIT_DIP] = dip_event;
        set_vec[`MESF_BIT_HIGH_CURR] = high_current_event_flag_set;
        set_vec[`MESF_BIT_HIGH_VOLT] = high_voltage_event_flag_set;
        set_vec[`MESF_BIT_ORDER_FAULT] = order_fault;
        set_vec[`MESF_BIT_IMBALANCE] = imbalance;
        set_vec[`MESF_BIT_PEAK_DONE] = current_peak_period_done;
        clr_vec = 32'h0000_0000;
        if (write_do && (write_idx == `MESF_STATUS_IDX))
            clr_vec = write_mask & `MESF_FLAG_MASK;
        // a set in the clearing cycle wins so no event is lost
        next_status = (((event_status_one & ~clr_vec) | set_vec) & `MESF_FLAG_MASK)
            | `MESF_STATUS_FIXED;
    end

    always @(posedge clock)
    begin
        if (srst || soft_default)
        begin
            event_status_one <= `MESF_STATUS_RESET;
            idle_phase_indicator_reg <= 9'h000;
            phase_event_status_reg <= 15'h0000;
            neutral_imbalance_threshold <= {CUR_W{1'b0}};
            current_peak_capture_reg <= 32'h0000_0000;
            seq_state <= SEQ_IDLE;
        end
        else
        begin
            event_status_one <= next_status;
            seq_state <= next_seq_state;
            if (idle_total_power_flag_set)
                idle_phase_indicator_reg[`MESF_FLD_IDLE_TOTAL+:3] <= idle_total_phase_field_in;
            if (idle_fundamental_power_flag_set)
                idle_phase_indicator_reg[`MESF_FLD_IDLE_FUND+:3] <=
                    idle_fundamental_phase_field_in;
            if (idle_apparent_power_flag_set)
                idle_phase_indicator_reg[`MESF_FLD_IDLE_APPAR+:3] <=
                    idle_apparent_phase_field_in;
            if (high_current_event_flag_set)
                phase_event_status_reg[`MESF_FLD_HIGH_CURR+:3] <= high_current_phase_field_in;
            if (high_voltage_event_flag_set)
                phase_event_status_reg[`MESF_FLD_HIGH_VOLT+:3] <= high_voltage_phase_field_in;
            if (dip_event)
                phase_event_status_reg[`MESF_FLD_DIP+:3] <= dip_phase_field_in;
            if (current_peak_period_done)
            begin
                current_peak_capture_reg <= 32'h0000_0000;
                current_peak_capture_reg[PEAK_W-1:0] <= current_peak_value;
                current_peak_capture_reg[`MESF_FLD_PEAK_PHASE+:3] <= current_peak_phase;
            end
            if (write_do && (write_idx == `MESF_IMBAL_THR_IDX))
                // enabled bytes take the written value, zeros included; other bytes keep theirs
                neutral_imbalance_threshold <= (neutral_imbalance_threshold & ~write_bytes[CUR_W-1:0])
                    | write_mask[CUR_W-1:0];
        end
    end

    always @(posedge clock)
    begin
        if (srst)
        begin
            power_mode_prev <= `MESF_MODE_NORMAL;
            second_interrupt_line_n <= 1'b1;
        end
        else
        begin
            power_mode_prev <= power_mode;
            // no mask: the line follows the reset-done flag alone
            second_interrupt_line_n <= ~event_status_one[`MESF_BIT_RESET_DONE];
        end
    end

    // write channel: address and data are taken in either order, one write at a time
    always @(posedge clock)
    begin
        if (srst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MESF_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {`MESF_ADDR_W{1'b0}};
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (!aw_held && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (!w_held && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
            if (write_do)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mesf_mapped(write_idx) ? `MESF_RESP_OKAY : `MESF_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // reads have no side effect on any flag
    always @(posedge clock)
    begin
        if (srst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MESF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mesf_mapped(mesf_index(s_axi_araddr)) ?
                `MESF_RESP_OKAY : `MESF_RESP_SLVERR;
            case (mesf_index(s_axi_araddr))
                `MESF_STATUS_IDX: s_axi_rdata <= event_status_one;
                `MESF_IDLE_PHASE_IDX: s_axi_rdata <= {23'h000000, idle_phase_indicator_reg};
                `MESF_PHASE_EVT_IDX: s_axi_rdata <= {17'h00000, phase_event_status_reg};
                `MESF_IMBAL_THR_IDX: s_axi_rdata <= {{(32-CUR_W){1'b0}}, neutral_imbalance_threshold};
                `MESF_PEAK_CAP_IDX: s_axi_rdata <= current_peak_capture_reg;
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

endmodule

// >>> sim/mesf_event_status_sva.sv
// bus handshake and interrupt assertions for the event status block
`include "mesf_event_status_regs.vh"
module mesf_event_status_sva (
    input wire clock,
    input wire srst,
    input wire [`MESF_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire software_reset_command,
    input wire [1:0] power_mode,
    input wire second_interrupt_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [`MESF_IDX_W-1:0] rd_idx;
    wire rd_mapped;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // the read answer comes later than its address, so keep the index
    always @(posedge clock)
    begin
        if (srst)
            rd_idx <= 16'h0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_idx <= s_axi_araddr[`MESF_ADDR_W-1:2];
    end
    assign rd_mapped = (rd_idx == `MESF_STATUS_IDX) || (rd_idx[15:2] == 14'h3980);
    chk_irq_soft_reset: assert property (software_reset_command |-> ##2 !second_interrupt_line_n)
        else $error("interrupt not low after soft reset");
    chk_irq_mode_return: assert property (!$past(srst) && $past(power_mode) != 2'h0
        && power_mode == 2'h0 |-> ##2 !second_interrupt_line_n)
        else $error("interrupt not low after return to normal mode");
    chk_irq_hard_reset: assert property ($fell(srst) |=> !second_interrupt_line_n)
        else $error("interrupt not low after hardware reset");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read valid held after handshake");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after request");
    chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    chk_write_refused: assert property (s_axi_awvalid && s_axi_awready |=> (!s_axi_awready) [*2])
        else $error("write address accepted while busy");
    chk_read_code: assert property (s_axi_rvalid |-> s_axi_rresp == (rd_mapped ? `MESF_RESP_OKAY
        : `MESF_RESP_SLVERR) && (rd_mapped || s_axi_rdata == 32'h0))
        else $error("wrong read response code or data");
    chk_status_fixed_bits: assert property (s_axi_rvalid && rd_idx == `MESF_STATUS_IDX
        |-> s_axi_rdata[22:21] == 2'h1 && s_axi_rdata[31:24] == 8'h0)
        else $error("status reserved bits wrong");
    cover property (software_reset_command);
    cover property (s_axi_rvalid && !rd_mapped);
    cover property (s_axi_rvalid && rd_idx == `MESF_STATUS_IDX);
endmodule

// >>> sim/mesf_event_status_tb.sv
// self-checking bench for the metering event status block
`include "mesf_event_status_regs.vh"
bind mesf_event_status mesf_event_status_sva mesf_event_status_sva_inst (
    .clock, .srst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .software_reset_command, .power_mode, .second_interrupt_line_n
);
module mesf_event_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ST = `MESF_STATUS_IDX;
    localparam logic [1:0] OK = `MESF_RESP_OKAY;
    localparam logic [1:0] ERR = `MESF_RESP_SLVERR;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [17:0] s_axi_awaddr = '0;
    logic [17:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire second_interrupt_line_n;
    logic [23:0] ev = '0;
    logic [2:0] ph = '0;
    logic [1:0] power_mode = '0;
    logic [27:0] cur_sum = '0;
    logic [27:0] cur_neu = '0;
    logic [23:0] peak = '0;
    int miscompares = 0;
    int compares = 0;
    mesf_event_status mesf_event_status_inst (
        .clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .idle_total_power_flag_set(ev[0]), .idle_total_phase_field_in(ph),
        .idle_fundamental_power_flag_set(ev[1]), .idle_fundamental_phase_field_in(ph),
        .idle_apparent_power_flag_set(ev[2]), .idle_apparent_phase_field_in(ph),
        .missing_crossing_volt_a(ev[3]), .missing_crossing_volt_b(ev[4]),
        .missing_crossing_volt_c(ev[5]), .missing_crossing_curr_a(ev[6]),
        .missing_crossing_curr_b(ev[7]), .missing_crossing_curr_c(ev[8]),
        .crossing_seen_volt_a(ev[9]), .crossing_seen_volt_b(ev[10]), .crossing_seen_volt_c(ev[11]),
        .crossing_seen_curr_a(ev[12]), .crossing_seen_curr_b(ev[13]), .crossing_seen_curr_c(ev[14]),
        .software_reset_command(ev[15]), .dip_event(ev[16]), .dip_phase_field_in(ph),
        .high_current_event_flag_set(ev[17]), .high_current_phase_field_in(ph),
        .high_voltage_event_flag_set(ev[18]), .high_voltage_phase_field_in(ph),
        .neutral_check_strobe(ev[19]), .phase_current_total(cur_sum),
        .neutral_current_sample(cur_neu), .current_peak_period_done(ev[20]),
        .current_peak_value(peak), .current_peak_phase(ph), .crossing_rise_volt_a(ev[21]),
        .crossing_rise_volt_b(ev[22]), .crossing_rise_volt_c(ev[23]), .power_mode,
        .second_interrupt_line_n
    );
    initial
    begin
        forever #20 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // each task ends one edge after its release so the next call never reassigns in one step
    task automatic wr(input logic [15:0] idx, input logic [31:0] data, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= data;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge clock);
            if (aw && s_axi_awready)
            begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do
            @(posedge clock);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clock);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge clock);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge clock);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clock);
    endtask
    task automatic pulse(input logic [23:0] m, input logic [2:0] p);
        ev <= m;
        ph <= p;
        @(posedge clock);
        ev <= '0;
        @(posedge clock);
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        check({31'h0, second_interrupt_line_n}, 32'h0);
        rd(ST, 32'h0020_8000, OK);
        wr(ST, 32'h0000_8000, OK);
        @(posedge clock);
        check({31'h0, second_interrupt_line_n}, 32'h1);
        for (int i = 0; i < 19; i++)
        begin
            if (i != 15)
            begin
                pulse(24'h1 << i, 3'(i % 7 + 1));
                wr(ST, ~(32'h1 << i), OK);
                rd(ST, 32'h0020_0000 | (32'h1 << i), OK);
                wr(ST, 32'h1 << i, OK);
                rd(ST, 32'h0020_0000, OK);
            end
        end
        rd(`MESF_IDLE_PHASE_IDX, 32'h0000_00D1, OK);
        rd(`MESF_PHASE_EVT_IDX, 32'h0000_3A20, OK);
        // rising order A B C, then A followed by B and C together, then A C
        pulse(24'h20_0000, 3'h0);
        pulse(24'h40_0000, 3'h0);
        pulse(24'h80_0000, 3'h0);
        pulse(24'h20_0000, 3'h0);
        pulse(24'hC0_0000, 3'h0);
        rd(ST, 32'h0020_0000, OK);
        pulse(24'h20_0000, 3'h0);
        pulse(24'h80_0000, 3'h0);
        rd(ST, 32'h0028_0000, OK);
        wr(ST, 32'h0008_0000, OK);
        wr(`MESF_IMBAL_THR_IDX, 32'h0000_0064, OK);
        rd(`MESF_IMBAL_THR_IDX, 32'h0000_0064, OK);
        cur_sum <= 28'h000_0096;
        cur_neu <= 28'hFFF_FFCE;
        pulse(24'h08_0000, 3'h0);
        rd(ST, 32'h0020_0000, OK);
        cur_sum <= 28'hFFF_FF38;
        cur_neu <= 28'h000_0063;
        pulse(24'h08_0000, 3'h0);
        rd(ST, 32'h0030_0000, OK);
        // a rewrite must also clear threshold bits that were set before
        wr(`MESF_IMBAL_THR_IDX, 32'h0000_0050, OK);
        rd(`MESF_IMBAL_THR_IDX, 32'h0000_0050, OK);
        peak <= 24'hAB_CDEF;
        pulse(24'h10_0000, 3'h6);
        rd(ST, 32'h00B0_0000, OK);
        rd(`MESF_PEAK_CAP_IDX, 32'h06AB_CDEF, OK);
        pulse(24'h00_8000, 3'h0);
        @(posedge clock);
        check({31'h0, second_interrupt_line_n}, 32'h0);
        rd(ST, 32'h0020_8000, OK);
        rd(`MESF_IMBAL_THR_IDX, 32'h0, OK);
        rd(`MESF_PEAK_CAP_IDX, 32'h0, OK);
        wr(ST, 32'h0000_8000, OK);
        pulse(24'h00_0200, 3'h0);
        power_mode <= 2'h2;
        @(posedge clock);
        power_mode <= 2'h0;
        repeat (3) @(posedge clock);
        check({31'h0, second_interrupt_line_n}, 32'h0);
        rd(ST, 32'h0020_8000, OK);
        // moving between two low-power modes is no return; only the final step to normal is
        wr(ST, 32'h0000_8000, OK);
        power_mode <= 2'h3;
        @(posedge clock);
        power_mode <= 2'h1;
        @(posedge clock);
        power_mode <= 2'h0;
        repeat (3) @(posedge clock);
        check({31'h0, second_interrupt_line_n}, 32'h0);
        // unmapped place refuses; the read-only capture register ignores writes
        rd(16'h0000, 32'h0, ERR);
        wr(16'h0000, 32'hFFFF_FFFF, ERR);
        wr(`MESF_PEAK_CAP_IDX, 32'hFFFF_FFFF, OK);
        rd(`MESF_PEAK_CAP_IDX, 32'h0, OK);
        rd(ST, 32'h0020_8000, OK);
        end_of_test;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test;
    end
endmodule
